// [src/plu_map.svh]
// Purpose: Register map and field layout of the lockstep update control
// Assumes: 32-bit register words at byte addresses
// Notes: Included by the package and the testbench
`ifndef PLU_MAP_SVH
`define PLU_MAP_SVH

`define PLU_ADDR_W 32
`define PLU_DATA_W 32
`define PLU_NUM_CH 8
`define PLU_INT_W 4

`define PLU_OFS_MODE 32'h40094020
`define PLU_OFS_TRIG 32'h40094028
`define PLU_OFS_INTV 32'h4009402c
`define PLU_OFS_SHAD 32'h40094030

`define PLU_MEMBER_LSB 0
`define PLU_MODE_LSB 16
`define PLU_MODE_MSB 17
`define PLU_REQMODE_BIT 20
`define PLU_CMPSEL_LSB 21
`define PLU_CMPSEL_MSB 23
`define PLU_UNLOCK_BIT 0
`define PLU_INTV_LSB 0
`define PLU_INTV_MSB 3
`define PLU_ICNT_LSB 4
`define PLU_ICNT_MSB 7

`define PLU_RST_MEMBER 8'h00
`define PLU_RST_MODE 2'h0
`define PLU_RST_CMPSEL 3'h0
`define PLU_RST_INTV 4'h0
`define PLU_RST_DATA 32'h00000000

`endif

// [src/plu_pkg.sv]
// Purpose: Types of the lockstep update control
// Assumes: Constants come from plu_map.svh
// Notes: Mode order follows the update-mode field encoding
`include "plu_map.svh"
package plu_pkg;
    typedef enum logic [1:0] {
        MANUAL_UPDATE_SETTING,
        AUTO_UPDATE_SETTING,
        DMA_AUTO_UPDATE_SETTING,
        RESERVED_UPDATE_SETTING
    } plu_mode_e;
    typedef logic [`PLU_INT_W-1:0] plu_intv_t;
    typedef logic [`PLU_DATA_W-1:0] plu_word_t;
endpackage

// [src/plu_top.sv]
// Purpose: Lockstep group update control for a set of PWM channels
// Assumes: periodStart pulses once at the start of each grouped period
// Notes: Register reads answer one cycle after the read strobe
`timescale 1ns/100ps
module plu_top
    import plu_pkg::*;
#(
    parameter int NUM_CH = `PLU_NUM_CH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [`PLU_ADDR_W-1:0] regAddr,
    input wire logic [`PLU_DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [`PLU_DATA_W-1:0] regRdata,
    input wire logic softProtectStatusGroup2,
    input wire logic hardProtectStatusGroup2,
    input wire logic periodStart,
    input wire logic [7:0] compareMatch,
    input wire logic status2Read,
    output logic [NUM_CH-1:0] groupMemberBits,
    output logic [1:0] updateModeField,
    output logic applyPeriodDeadtime,
    output logic applyDuty,
    output logic writeReadyFlag,
    output logic dmaRequest
);

    logic [NUM_CH-1:0] member_q;
    plu_mode_e mode_q;
    logic reqMode_q;
    logic [2:0] cmpSel_q;
    logic unlock_q;
    plu_intv_t intv_q;
    plu_intv_t intvCnt_q;
    plu_intv_t intvShadow_q;
    plu_word_t rdata_q;
    logic write_ready_flag_q;
    logic dma_q;
    logic applyPd_q;
    logic applyDuty_q;

    logic wrMode;
    logic wrTrig;
    logic wrShad;
    logic autoMode;
    logic elapsed;
    logic unlockDone;
    logic cmpHit;
    logic readySet;
    logic dmaSet;

    function automatic logic hit(input logic [`PLU_ADDR_W-1:0] a,
                                 input logic [`PLU_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic isAuto(input plu_mode_e m);
        isAuto = (m == AUTO_UPDATE_SETTING) ||
                 (m == DMA_AUTO_UPDATE_SETTING);
    endfunction

    // Write decode
    assign wrMode = regWr && hit(regAddr, `PLU_OFS_MODE) &&
                    !softProtectStatusGroup2 &&
                    !hardProtectStatusGroup2;
    assign wrTrig = regWr && hit(regAddr, `PLU_OFS_TRIG);
    assign wrShad = regWr && hit(regAddr, `PLU_OFS_SHAD);

    // Mode register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            member_q <= NUM_CH'(`PLU_RST_MEMBER);
            mode_q <= plu_mode_e'(`PLU_RST_MODE);
            reqMode_q <= 1'b0;
            cmpSel_q <= `PLU_RST_CMPSEL;
        end else if (wrMode) begin
            member_q <= regWdata[`PLU_MEMBER_LSB +: NUM_CH];
            mode_q <= plu_mode_e'(
                regWdata[`PLU_MODE_MSB:`PLU_MODE_LSB]);
            reqMode_q <= regWdata[`PLU_REQMODE_BIT];
            cmpSel_q <= regWdata[`PLU_CMPSEL_MSB:`PLU_CMPSEL_LSB];
        end
    end

    assign groupMemberBits = member_q;
    assign updateModeField = mode_q;

    // Reserved mode 3 is treated as manual
    assign autoMode = isAuto(mode_q);
    assign elapsed = autoMode && periodStart &&
                     (intvCnt_q == intv_q);
    assign unlockDone = unlock_q && periodStart;

    // Unlock bit, a new write of 1 wins over the self clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            unlock_q <= 1'b0;
        end else if (wrTrig && regWdata[`PLU_UNLOCK_BIT]) begin
            unlock_q <= 1'b1;
        end else if (unlockDone) begin
            unlock_q <= 1'b0;
        end
    end

    // Interval counter and shadow
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            intvShadow_q <= `PLU_RST_INTV;
        end else if (wrShad) begin
            intvShadow_q <= regWdata[`PLU_INTV_MSB:`PLU_INTV_LSB];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            intv_q <= `PLU_RST_INTV;
            intvCnt_q <= `PLU_RST_INTV;
        end else if (elapsed) begin
            intvCnt_q <= `PLU_RST_INTV;
            intv_q <= intvShadow_q;
        end else if (autoMode && periodStart) begin
            intvCnt_q <= intvCnt_q + plu_intv_t'(1);
        end
    end

    // Apply pulses toward the channel logic
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            applyPd_q <= 1'b0;
            applyDuty_q <= 1'b0;
        end else begin
            applyPd_q <= unlockDone || elapsed;
            applyDuty_q <= (unlockDone && !autoMode) ||
                           elapsed;
        end
    end

    assign applyPeriodDeadtime = applyPd_q;
    assign applyDuty = applyDuty_q;

    // Write-ready and DMA request
    assign cmpHit = compareMatch[cmpSel_q];
    assign dmaSet = (mode_q == DMA_AUTO_UPDATE_SETTING) &&
                    (reqMode_q ? cmpHit : elapsed);
    assign readySet = dmaSet ||
                      ((mode_q == AUTO_UPDATE_SETTING) && elapsed);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            write_ready_flag_q <= 1'b0;
        end else if (readySet) begin
            write_ready_flag_q <= 1'b1;
        end else if (status2Read) begin
            write_ready_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dma_q <= 1'b0;
        end else begin
            dma_q <= dmaSet;
        end
    end

    assign writeReadyFlag = write_ready_flag_q;
    assign dmaRequest = dma_q;

    // Read path, one cycle latency
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_q <= `PLU_RST_DATA;
        end else if (regRd) begin
            rdata_q <= `PLU_RST_DATA;
            if (hit(regAddr, `PLU_OFS_MODE)) begin
                rdata_q[`PLU_MEMBER_LSB +: NUM_CH] <= member_q;
                rdata_q[`PLU_MODE_MSB:`PLU_MODE_LSB] <= mode_q;
                rdata_q[`PLU_REQMODE_BIT] <= reqMode_q;
                rdata_q[`PLU_CMPSEL_MSB:`PLU_CMPSEL_LSB] <= cmpSel_q;
            end else if (hit(regAddr, `PLU_OFS_TRIG)) begin
                rdata_q[`PLU_UNLOCK_BIT] <= unlock_q;
            end else if (hit(regAddr, `PLU_OFS_INTV)) begin
                rdata_q[`PLU_INTV_MSB:`PLU_INTV_LSB] <= intv_q;
                rdata_q[`PLU_ICNT_MSB:`PLU_ICNT_LSB] <= intvCnt_q;
            end
        end else begin
            rdata_q <= `PLU_RST_DATA;
        end
    end

    assign regRdata = rdata_q;

    // Checks
    a_protect_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWr && hit(regAddr, `PLU_OFS_MODE) &&
         (softProtectStatusGroup2 || hardProtectStatusGroup2))
        |=> $stable(mode_q) && $stable(member_q))
        else $error("mode register changed while protected");

    a_manual_update_setting_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q == MANUAL_UPDATE_SETTING) && $past(mode_q) ==
        MANUAL_UPDATE_SETTING |-> !dmaRequest && !$rose(writeReadyFlag))
        else $error("request or ready raised in manual mode");

    a_auto_update_setting_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q == AUTO_UPDATE_SETTING) && elapsed
        |=> writeReadyFlag && !dmaRequest)
        else $error("mode 1 interval end handled wrongly");

    a_dma_auto_update_setting_interval: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        (mode_q == DMA_AUTO_UPDATE_SETTING) && !reqMode_q && elapsed
        |=> writeReadyFlag && dmaRequest)
        else $error("mode 2 interval end did not request");

    a_dma_auto_update_setting_compare: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q == DMA_AUTO_UPDATE_SETTING) && reqMode_q &&
        compareMatch[cmpSel_q] |=> writeReadyFlag && dmaRequest)
        else $error("selected comparison did not request");

    a_unlock_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        unlock_q && periodStart && !wrTrig
        |=> !unlock_q && applyPeriodDeadtime)
        else $error("unlock did not clear after update");

    a_manual_duty: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !autoMode && unlock_q && periodStart |=> applyDuty)
        else $error("manual unlock did not apply duty");

    a_auto_no_duty: assert property (@(posedge clk_sys) disable iff (!rst_n)
        autoMode && unlock_q && periodStart && !elapsed
        |=> applyPeriodDeadtime && !applyDuty)
        else $error("auto unlock applied duty");

    a_interval_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        elapsed |=> intvCnt_q == 4'h0 && intv_q == $past(intvShadow_q))
        else $error("interval counter did not restart");

    a_ready_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
        writeReadyFlag && !status2Read |=> writeReadyFlag)
        else $error("write-ready dropped without status read");

    a_count_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regRd && hit(regAddr, `PLU_OFS_INTV)
        |=> regRdata[7:4] == $past(intvCnt_q))
        else $error("interval counter read wrong");

    a_member_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrMode |=> groupMemberBits == $past(regWdata[NUM_CH-1:0]))
        else $error("member bits not taken from write");

    a_member_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wrMode |=> $stable(groupMemberBits))
        else $error("member bits changed without write");

    a_mode_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrMode |=> updateModeField == $past(regWdata[17:16]))
        else $error("update mode not taken from write");

    a_manual_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !autoMode && !unlock_q |=> !applyPeriodDeadtime && !applyDuty)
        else $error("manual mode applied without unlock");

    a_auto_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q == AUTO_UPDATE_SETTING) && elapsed
        |=> applyPeriodDeadtime && applyDuty)
        else $error("mode 1 interval end did not apply");

    a_dma_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q == DMA_AUTO_UPDATE_SETTING) && elapsed
        |=> applyPeriodDeadtime && applyDuty)
        else $error("mode 2 interval end did not apply");

    a_manual_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !autoMode && unlock_q && periodStart |=> applyPeriodDeadtime)
        else $error("manual unlock did not apply period");

    a_apply_at_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !periodStart |=> !applyPeriodDeadtime && !applyDuty)
        else $error("apply pulse outside a period start");

    a_no_dma_else: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode_q != DMA_AUTO_UPDATE_SETTING |=> !dmaRequest)
        else $error("request raised outside mode 2");

    a_auto_update_setting_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q == AUTO_UPDATE_SETTING) && !elapsed && !writeReadyFlag
        |=> !writeReadyFlag)
        else $error("mode 1 ready set before interval end");

    a_interval_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q == DMA_AUTO_UPDATE_SETTING) && !reqMode_q && !elapsed
        |=> !dmaRequest)
        else $error("mode 2 request without interval end");

    a_match_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q == DMA_AUTO_UPDATE_SETTING) && reqMode_q &&
        !compareMatch[cmpSel_q] |=> !dmaRequest)
        else $error("request without selected match");

    a_unlock_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrTrig && regWdata[0] |=> unlock_q)
        else $error("unlock write of one not taken");

    a_unlock_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrTrig && !regWdata[0] && !unlock_q |=> !unlock_q)
        else $error("unlock write of zero had effect");

    a_unlock_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        unlock_q && !periodStart |=> unlock_q)
        else $error("unlock cleared before update");

    a_auto_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
        autoMode && unlock_q && periodStart |=> applyPeriodDeadtime)
        else $error("auto unlock did not apply period");

    a_count_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        autoMode && periodStart && !elapsed
        |=> intvCnt_q == $past(intvCnt_q) + 4'h1)
        else $error("interval counter did not step");

    a_count_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(autoMode && periodStart) |=> $stable(intvCnt_q))
        else $error("interval counter moved without period");

    a_active_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !elapsed |=> $stable(intv_q))
        else $error("active interval changed before expiry");

    a_shadow_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrShad |=> intvShadow_q == $past(regWdata[3:0]))
        else $error("shadow interval not taken from write");

    a_shadow_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regRd && hit(regAddr, `PLU_OFS_SHAD) |=> regRdata == 32'h0)
        else $error("shadow register read not zero");

    a_ready_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        status2Read && !readySet |=> !writeReadyFlag)
        else $error("write-ready not cleared by status read");

    a_intv_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regRd && hit(regAddr, `PLU_OFS_INTV)
        |=> regRdata[3:0] == $past(intv_q))
        else $error("interval value read wrong");

    a_idle_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !regRd |=> regRdata == 32'h0)
        else $error("read data outside read answer");

endmodule

// [verification/plu_top_tb.sv]
// Purpose: Self-checking bench for the lockstep update control
// Assumes: Registered outputs settle just after the sampling clock edge
// Notes: Pulses are caught over two cycles after each event
`timescale 1ns/100ps
`include "plu_map.svh"
module plu_top_tb
    import plu_pkg::*;
;
    logic clk_sys, rst_n, regWr, regRd, periodStart, status2Read;
    logic softProtectStatusGroup2, hardProtectStatusGroup2;
    logic [31:0] regAddr, regWdata, regRdata, rd;
    logic [7:0] compareMatch, groupMemberBits;
    logic [1:0] updateModeField;
    logic applyPeriodDeadtime, applyDuty, writeReadyFlag, dmaRequest;
    logic [2:0] seen;
    int error_cnt = 0;
    int cmp_count = 0;

    plu_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata),
        .softProtectStatusGroup2(softProtectStatusGroup2),
        .hardProtectStatusGroup2(hardProtectStatusGroup2),
        .periodStart(periodStart), .compareMatch(compareMatch),
        .status2Read(status2Read), .groupMemberBits(groupMemberBits),
        .updateModeField(updateModeField),
        .applyPeriodDeadtime(applyPeriodDeadtime), .applyDuty(applyDuty),
        .writeReadyFlag(writeReadyFlag), .dmaRequest(dmaRequest));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic end_sim();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 chk(regRdata, exp);
    endtask

    // One period start or match event; seen = {perDt, duty, dma}
    task automatic evt(input logic ps, input logic [7:0] cm);
        @(posedge clk_sys);
        periodStart <= ps;
        compareMatch <= cm;
        @(posedge clk_sys);
        periodStart <= 1'b0;
        compareMatch <= 8'h00;
        #1 seen = {applyPeriodDeadtime, applyDuty, dmaRequest};
        @(posedge clk_sys);
        #1 seen = seen | {applyPeriodDeadtime, applyDuty, dmaRequest};
    endtask

    // n periods: only the last one gives exp
    task automatic periods(input int n, input logic [2:0] exp);
        for (int i = 1; i <= n; i++) begin
            evt(1'b1, 8'h00);
            chk({29'h0, seen}, (i == n) ? {29'h0, exp} : 32'h0);
        end
    endtask

    task automatic clrReady();
        @(posedge clk_sys);
        status2Read <= 1'b1;
        @(posedge clk_sys);
        status2Read <= 1'b0;
        #1 chk({31'h0, writeReadyFlag}, 32'h0);
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        end_sim();
    end

    initial begin
        rst_n = 1'b0;
        {regWr, regRd, periodStart, status2Read} = 4'h0;
        {softProtectStatusGroup2, hardProtectStatusGroup2} = 2'h0;
        regAddr = 32'h0;
        regWdata = 32'h0;
        compareMatch = 8'h00;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdChk(`PLU_OFS_MODE, 32'h0);
        for (int p = 1; p < 3; p++) begin
            {softProtectStatusGroup2, hardProtectStatusGroup2} <= p[1:0];
            wr(`PLU_OFS_MODE, 32'h000100a5);
            rdChk(`PLU_OFS_MODE, 32'h0);
        end
        {softProtectStatusGroup2, hardProtectStatusGroup2} <= 2'h0;
        wr(`PLU_OFS_MODE, 32'h000000a5);
        rdChk(`PLU_OFS_MODE, 32'h000000a5);
        chk({24'h0, groupMemberBits}, 32'h000000a5);
        chk({30'h0, updateModeField}, {30'h0, MANUAL_UPDATE_SETTING});
        rdChk(32'h40094024, 32'h0);
        wr(`PLU_OFS_SHAD, 32'h00000002);
        rdChk(`PLU_OFS_SHAD, 32'h0);
        periods(1, 3'b000);
        wr(`PLU_OFS_TRIG, 32'h0);
        periods(1, 3'b000);
        wr(`PLU_OFS_TRIG, 32'h1);
        rdChk(`PLU_OFS_TRIG, 32'h1);
        periods(1, 3'b110);
        rdChk(`PLU_OFS_TRIG, 32'h0);
        chk({31'h0, writeReadyFlag}, 32'h0);
        wr(`PLU_OFS_MODE, 32'h000100a5);
        periods(1, 3'b110);
        chk({31'h0, writeReadyFlag}, 32'h1);
        rdChk(`PLU_OFS_INTV, 32'h00000002);
        clrReady();
        periods(1, 3'b000);
        rdChk(`PLU_OFS_INTV, 32'h00000012);
        periods(2, 3'b110);
        wr(`PLU_OFS_TRIG, 32'h1);
        periods(1, 3'b100);
        periods(2, 3'b110);
        wr(`PLU_OFS_MODE, 32'h000200a5);
        clrReady();
        periods(3, 3'b111);
        chk({31'h0, writeReadyFlag}, 32'h1);
        wr(`PLU_OFS_MODE, 32'h00b200a5);
        clrReady();
        evt(1'b0, 8'h10);
        chk({29'h0, seen}, 32'h0);
        chk({31'h0, writeReadyFlag}, 32'h0);
        evt(1'b0, 8'h20);
        chk({29'h0, seen}, 32'h1);
        chk({31'h0, writeReadyFlag}, 32'h1);
        wr(`PLU_OFS_MODE, 32'h000300a5);
        periods(1, 3'b000);
        end_sim();
    end
endmodule
